// file: include/llc_defines.svh
// constants for the low latency dram command controller: widths, command codes, counts
// assumes inclusion by bare name from the package and the design files
`ifndef LLC_DEFINES_SVH
`define LLC_DEFINES_SVH

// memory address and bank widths carried in the command struct
`define LLC_ADDR_W       20
`define LLC_BA_W         3
// number of banks refreshed one after another during initialization
`define LLC_NUM_BANKS    8
// mode program sequence: total cycles and index of the configuration cycle
`define LLC_MRS_CYCLES   4'ha
`define LLC_MRS_CFG_IDX  4'h9
// default delay from taking a write request to asking for its data, in cycles
`define LLC_WRITE_LAT    5
// command pin codes {cs_n, we_n, ref_n}
`define LLC_CMD_NOP      3'h7
`define LLC_CMD_MODE     3'h0
`define LLC_CMD_READ     3'h3
`define LLC_CMD_WRITE    3'h1
`define LLC_CMD_REFRESH  3'h2
// ddr output pair for the memory clock: rising half high, falling half low
`define LLC_MEM_CLK_PAIR 2'h2

`endif

// file: include/llc_pkg.sv
// types shared by the command controller and the memory model
// assumes llc_defines.svh is on the include path
`include "llc_defines.svh"

package llc_pkg;

   // init and run states, one-hot
   typedef enum logic [2:0] {
      ST_MODE = 3'h1,   // mode program commands
      ST_REF  = 3'h2,   // per-bank refresh walk
      ST_RUN  = 3'h4    // normal traffic
   } llc_state_e;

   // one memory command cycle as driven on the address and command pins
   typedef struct packed {
      logic [2:0]               code;  // {cs_n, we_n, ref_n}
      logic [`LLC_BA_W-1:0]     ba;    // bank address
      logic [`LLC_ADDR_W-1:0]   addr;  // address / configuration word
   } llc_cmd_s;

endpackage

// file: logic/llc_capture.sv
// one read capture channel: picks strobe or external capture clock, finds its rising edges
// assumes all pin inputs are asynchronous to i_clock and clocks are far slower than i_clock
module llc_capture #(
   parameter int DQ_W = 18
) (
   input  wire logic            i_clock,
   input  wire logic            i_arst_n,
   input  wire logic            i_strobe_mode,
   input  wire logic            i_strobe,
   input  wire logic            i_ext_clk,
   input  wire logic            i_qvld,
   input  wire logic [DQ_W-1:0] i_data,
   output logic                 o_capture_clk,
   output logic                 o_rdata_valid,
   output logic [DQ_W-1:0]      o_rdata
);

   // two-stage synchronisers; stage one feeds only stage two
   logic [1:0]      strb_s1_r, strb_s1_nxt;   // {ext, strobe} first stage
   logic [1:0]      strb_s2_r, strb_s2_nxt;   // second stage
   logic            qv_s1_r, qv_s1_nxt;
   logic            qv_s2_r, qv_s2_nxt;
   logic [DQ_W-1:0] dat_s1_r, dat_s1_nxt;
   logic [DQ_W-1:0] dat_s2_r, dat_s2_nxt;
   logic            clk_d_r, clk_d_nxt;       // selected clock, one cycle late
   logic            vld_r, vld_nxt;
   logic [DQ_W-1:0] rdat_r, rdat_nxt;
   logic            sel_clk;                  // capture clock in use
   logic            edge_rise;

   // data is synchronised with the same depth as the clock so they stay aligned;
   // only fields that hold steady around the capture edge are caught cleanly
   always_comb begin
      strb_s1_nxt = {i_ext_clk, i_strobe};
      strb_s2_nxt = strb_s1_r;
      qv_s1_nxt   = i_qvld;
      qv_s2_nxt   = qv_s1_r;
      dat_s1_nxt  = i_data;
      dat_s2_nxt  = dat_s1_r;
      // strobe mode uses the memory strobe, otherwise the external clock
      sel_clk     = i_strobe_mode ? strb_s2_r[0] : strb_s2_r[1];
      edge_rise   = sel_clk & ~clk_d_r;
      clk_d_nxt   = sel_clk;
      // sample data and valid only on capture clock edges
      vld_nxt     = edge_rise & qv_s2_r;
      rdat_nxt    = edge_rise ? dat_s2_r : rdat_r;
   end

   // registers only
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         strb_s1_r <= 2'h0;
         strb_s2_r <= 2'h0;
         qv_s1_r   <= 1'b0;
         qv_s2_r   <= 1'b0;
         dat_s1_r  <= '0;
         dat_s2_r  <= '0;
         clk_d_r   <= 1'b0;
         vld_r     <= 1'b0;
         rdat_r    <= '0;
      end else begin
         strb_s1_r <= strb_s1_nxt;
         strb_s2_r <= strb_s2_nxt;
         qv_s1_r   <= qv_s1_nxt;
         qv_s2_r   <= qv_s2_nxt;
         dat_s1_r  <= dat_s1_nxt;
         dat_s2_r  <= dat_s2_nxt;
         clk_d_r   <= clk_d_nxt;
         vld_r     <= vld_nxt;
         rdat_r    <= rdat_nxt;
      end
   end

   assign o_capture_clk = clk_d_r;
   assign o_rdata_valid = vld_r;
   assign o_rdata       = rdat_r;

   // valid follows a sampled edge with the read valid pin high
   a_capture_valid: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (edge_rise && qv_s2_r) |=> (o_rdata_valid && o_rdata == $past(dat_s2_r)))
      else $error("read valid not raised with captured data");
   // no valid without an edge of the chosen clock
   a_capture_edge: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      o_rdata_valid |-> ($past(sel_clk) && !$past(clk_d_r)))
      else $error("read valid without capture clock edge");

endmodule

// file: logic/llc_cmd_ctrl.sv
// command and control logic of the low latency dram controller, with read capture
// assumes user logic spaces and schedules requests; pin inputs are asynchronous
`include "llc_defines.svh"

module llc_cmd_ctrl #(
   parameter int NUM_DEV   = 1,
   parameter int DQ_W      = 18,
   parameter int WRITE_LAT = `LLC_WRITE_LAT,
   parameter int NUM_BANKS = `LLC_NUM_BANKS
) (
   input  wire logic                     i_clock,
   input  wire logic                     i_arst_n,
   input  wire logic                     i_write_req,
   input  wire logic                     i_read_req,
   input  wire logic                     i_refresh_req,
   input  wire logic [`LLC_ADDR_W-1:0]   i_addr,
   input  wire logic [`LLC_BA_W-1:0]     i_bank_addr,
   input  wire logic [`LLC_ADDR_W-1:0]   i_mode_config,
   input  wire logic                     i_strobe_mode,
   input  wire logic [NUM_DEV-1:0]       i_mem_read_strobe,
   input  wire logic [NUM_DEV-1:0]       i_mem_read_valid,
   input  wire logic                     i_ext_capture_clk,
   input  wire logic [NUM_DEV*DQ_W-1:0]  i_mem_rdata,
   output llc_pkg::llc_cmd_s             o_mem_cmd,
   output logic [1:0]                    o_mem_clk_ddr,
   output logic                          o_init_done,
   output logic                          o_wdata_req,
   output logic [NUM_DEV-1:0]            o_capture_clk,
   output logic [NUM_DEV-1:0]            o_rdata_valid,
   output logic [NUM_DEV*DQ_W-1:0]       o_rdata
);

   llc_pkg::llc_state_e  state_r, state_nxt;      // init / run state
   logic [3:0]           cnt_r, cnt_nxt;          // mode cycle or bank counter
   llc_pkg::llc_cmd_s    cmd_r, cmd_nxt;          // command pins register
   logic                 done_r, done_nxt;        // initialization finished
   logic [WRITE_LAT-1:0] wsh_r, wsh_nxt;          // write latency delay line
   logic [1:0]           mclk_r, mclk_nxt;        // memory clock ddr pair
   logic                 wr_take;                 // write taken this cycle
   logic                 rd_take;                 // read taken this cycle
   logic                 rf_take;                 // refresh taken this cycle

   // decision of the next command; one request per cycle, write beats read beats refresh
   always_comb begin
      state_nxt     = state_r;
      cnt_nxt       = cnt_r;
      cmd_nxt.code  = `LLC_CMD_NOP;
      cmd_nxt.ba    = '0;
      cmd_nxt.addr  = '0;
      wr_take       = 1'b0;
      rd_take       = 1'b0;
      rf_take       = 1'b0;
      case (state_r)
         llc_pkg::ST_MODE: begin
            // dummy mode commands keep the address low so the memory dll resets
            cmd_nxt.code = `LLC_CMD_MODE;
            if (cnt_r == `LLC_MRS_CFG_IDX) begin
               cmd_nxt.addr = i_mode_config;
            end
            if (cnt_r == `LLC_MRS_CYCLES - 4'h1) begin
               state_nxt = llc_pkg::ST_REF;
               cnt_nxt   = 4'h0;
            end else begin
               cnt_nxt = cnt_r + 4'h1;
            end
         end
         llc_pkg::ST_REF: begin
            // walk the banks one per cycle
            cmd_nxt.code = `LLC_CMD_REFRESH;
            cmd_nxt.ba   = cnt_r[`LLC_BA_W-1:0];
            if (cnt_r == 4'(NUM_BANKS - 1)) begin
               state_nxt = llc_pkg::ST_RUN;
               cnt_nxt   = 4'h0;
            end else begin
               cnt_nxt = cnt_r + 4'h1;
            end
         end
         llc_pkg::ST_RUN: begin
            // no spacing check: the winning request is sent on the next edge
            if (i_write_req) begin
               wr_take      = 1'b1;
               cmd_nxt.code = `LLC_CMD_WRITE;
               cmd_nxt.ba   = i_bank_addr;
               cmd_nxt.addr = i_addr;
            end else if (i_read_req) begin
               rd_take      = 1'b1;
               cmd_nxt.code = `LLC_CMD_READ;
               cmd_nxt.ba   = i_bank_addr;
               cmd_nxt.addr = i_addr;
            end else if (i_refresh_req) begin
               // each held cycle yields one refresh to that cycle's bank
               rf_take      = 1'b1;
               cmd_nxt.code = `LLC_CMD_REFRESH;
               cmd_nxt.ba   = i_bank_addr;
            end
         end
         default: begin
            state_nxt = llc_pkg::ST_MODE;
            cnt_nxt   = 4'h0;
         end
      endcase
      // requests before run fall through the case unserved
      done_nxt = (state_nxt == llc_pkg::ST_RUN);
      // write data asked for a fixed count after the write is taken
      wsh_nxt  = {wsh_r[WRITE_LAT-2:0], wr_take};
      // clock pair drives the same kind of ddr register as write data
      mclk_nxt = `LLC_MEM_CLK_PAIR;
   end

   // registers only
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r      <= llc_pkg::ST_MODE;
         cnt_r        <= 4'h0;
         cmd_r.code   <= `LLC_CMD_NOP;
         cmd_r.ba     <= '0;
         cmd_r.addr   <= '0;
         done_r       <= 1'b0;
         wsh_r        <= '0;
         mclk_r       <= 2'h0;
      end else begin
         state_r      <= state_nxt;
         cnt_r        <= cnt_nxt;
         cmd_r        <= cmd_nxt;
         done_r       <= done_nxt;
         wsh_r        <= wsh_nxt;
         mclk_r       <= mclk_nxt;
      end
   end

   assign o_mem_cmd     = cmd_r;
   assign o_init_done   = done_r;
   assign o_wdata_req   = wsh_r[WRITE_LAT-1];
   assign o_mem_clk_ddr = mclk_r;

   // one capture channel and capture clock per attached device
   for (genvar d = 0; d < NUM_DEV; d++) begin : g_cap
      llc_capture #(
         .DQ_W (DQ_W)
      ) u_cap (
         .i_clock       (i_clock),
         .i_arst_n      (i_arst_n),
         .i_strobe_mode (i_strobe_mode),
         .i_strobe      (i_mem_read_strobe[d]),
         .i_ext_clk     (i_ext_capture_clk),
         .i_qvld        (i_mem_read_valid[d]),
         .i_data        (i_mem_rdata[d*DQ_W +: DQ_W]),
         .o_capture_clk (o_capture_clk[d]),
         .o_rdata_valid (o_rdata_valid[d]),
         .o_rdata       (o_rdata[d*DQ_W +: DQ_W])
      );
   end

   // mode sequence: nine zero-address commands then the configuration word
   sequence s_mode_dummy;
      (o_mem_cmd.code == `LLC_CMD_MODE && o_mem_cmd.addr == '0) [*8];
   endsequence
   sequence s_mode_tail;
      (o_mem_cmd.code == `LLC_CMD_MODE && o_mem_cmd.addr == '0)
      ##1 (o_mem_cmd.code == `LLC_CMD_MODE && o_mem_cmd.addr == $past(i_mode_config));
   endsequence

   // anchored one edge into the walk: the release edge itself still leaves the reset values
   a_mode_sequence: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (state_r == llc_pkg::ST_MODE && cnt_r == 4'h1) |-> s_mode_dummy ##1 s_mode_tail)
      else $error("mode program sequence wrong");
   a_mode_config: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (state_r == llc_pkg::ST_MODE && cnt_r == 4'h9)
      |=> (o_mem_cmd.addr == $past(i_mode_config) && state_r == llc_pkg::ST_REF))
      else $error("configuration word not on tenth mode cycle");
   a_init_order: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (state_r == llc_pkg::ST_REF && cnt_r == 4'h0)
      |=> (o_mem_cmd.code == `LLC_CMD_REFRESH && o_mem_cmd.ba == '0)
      ##1 (o_mem_cmd.code == `LLC_CMD_REFRESH && o_mem_cmd.ba == 3'h1))
      else $error("bank refresh walk wrong");
   a_write_issue: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (o_init_done && i_write_req)
      |=> (o_mem_cmd.code == `LLC_CMD_WRITE && o_mem_cmd.addr == $past(i_addr)))
      else $error("write not issued at once");
   a_wdata_delay: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (o_init_done && i_write_req) |-> ##WRITE_LAT o_wdata_req)
      else $error("write data request not at write latency");
   a_read_issue: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (o_init_done && i_read_req && !i_write_req)
      |=> (o_mem_cmd.code == `LLC_CMD_READ && o_mem_cmd.ba == $past(i_bank_addr)))
      else $error("read not issued at once");
   a_back_to_back: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (o_init_done && i_write_req) ##1 (i_read_req && !i_write_req)
      |=> o_mem_cmd.code == `LLC_CMD_READ)
      else $error("close request was dropped");
   a_refresh_bank: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (o_init_done && i_refresh_req && !i_write_req && !i_read_req)
      |=> (o_mem_cmd.code == `LLC_CMD_REFRESH && o_mem_cmd.ba == $past(i_bank_addr)))
      else $error("refresh not issued to requested bank");
   a_ganged_refresh: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (o_init_done && rf_take) [*3] |=> (o_mem_cmd.code == `LLC_CMD_REFRESH
      && $past(o_mem_cmd.code) == `LLC_CMD_REFRESH))
      else $error("ganged refresh lost a command");
   a_ignore_init: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      !o_init_done |=> (o_mem_cmd.code == `LLC_CMD_MODE
      || o_mem_cmd.code == `LLC_CMD_REFRESH || o_mem_cmd.code == `LLC_CMD_NOP))
      else $error("traffic issued during initialization");

endmodule

// file: verif/llc_mem_model.sv
// behavioural memory device seen from the read side: returns one frame per read command, on the strobe or the external clock
// assumes the command struct from llc_pkg and a system clock far faster than the strobe
`include "llc_defines.svh"

module llc_mem_model (
   input  wire logic        i_clock,
   input  wire llc_pkg::llc_cmd_s i_cmd,
   input  wire logic        i_ext_sel,
   input  wire logic        i_slow,
   output logic             o_strobe,
   output logic             o_ext_clk,
   output logic             o_qvld,
   output logic [17:0]      o_data
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [17:0] pend_q [$];   // low read address bits waiting for their data frame

   // note each read command; data echoes the low address bits so the bench can predict it
   always @(posedge i_clock) begin
      if (i_cmd.code == `LLC_CMD_READ) begin
         pend_q.push_back(i_cmd.addr[17:0]);
      end
   end

   // one frame per read, 125 ns fast or 195 ns slow; clocks stand still between frames
   initial begin
      o_strobe  = 1'b0;
      o_ext_clk = 1'b0;
      o_qvld    = 1'b0;
      o_data    = 18'h0;
      forever begin
         while (pend_q.size() == 0) @(posedge i_clock);
         #(i_slow ? 90 : 20);
         o_data = pend_q.pop_front();
         o_qvld = 1'b1;
         #5;
         // only one capture source pulses, so a wrong mode choice loses the frame
         if (i_ext_sel) begin
            o_ext_clk = 1'b1;
         end else begin
            o_strobe = 1'b1;
         end
         #62.5;
         o_strobe  = 1'b0;
         o_ext_clk = 1'b0;
         o_qvld    = 1'b0;
         // released bus shows the inverse so stale data can never look right
         o_data    = ~o_data;
         // back to back fast frames give a 125 ns strobe period, half high and half low
         #37.5;
      end
   end
endmodule

// file: verif/low_latency_dram_command_ctrl_tb.sv
// self-checking bench: reference model of commands, write data requests and read capture
// assumes llc_mem_model on the memory side and reset released on a rising clock edge
`include "llc_defines.svh"

module low_latency_dram_command_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int WL = 4;             // shortened write latency, expectations follow it
   logic        i_clock, i_arst_n;
   logic        i_write_req, i_read_req, i_refresh_req, i_strobe_mode;
   logic [19:0] i_addr, i_mode_config;
   logic [2:0]  i_bank_addr;
   logic        ext_sel, slow;        // partner capture source and answer speed
   logic        strobe, ext_clk, qvld;
   logic [17:0] mem_data, o_rdata;
   llc_pkg::llc_cmd_s o_mem_cmd;
   logic [1:0]  o_mem_clk_ddr;
   logic        o_init_done, o_wdata_req, o_capture_clk, o_rdata_valid;
   int          miscompares = 0;
   int          tests_run   = 0;
   int          k           = 0;      // edges since reset release
   logic [15:0] pipe        = 16'h0;  // write takes, one bit per edge of age
   logic [17:0] rq [$];               // read data expected in order
   logic [31:0] seed        = 32'h0000003c;
   llc_pkg::llc_cmd_s exp_cmd = {3'h7, 23'h0};

   llc_cmd_ctrl #(.WRITE_LAT(WL)) i_dut (
      .i_clock(i_clock), .i_arst_n(i_arst_n), .i_write_req(i_write_req),
      .i_read_req(i_read_req), .i_refresh_req(i_refresh_req), .i_addr(i_addr),
      .i_bank_addr(i_bank_addr), .i_mode_config(i_mode_config),
      .i_strobe_mode(i_strobe_mode), .i_mem_read_strobe(strobe), .i_mem_read_valid(qvld),
      .i_ext_capture_clk(ext_clk), .i_mem_rdata(mem_data), .o_mem_cmd(o_mem_cmd),
      .o_mem_clk_ddr(o_mem_clk_ddr), .o_init_done(o_init_done), .o_wdata_req(o_wdata_req),
      .o_capture_clk(o_capture_clk), .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata));

   llc_mem_model i_mem (
      .i_clock(i_clock), .i_cmd(o_mem_cmd), .i_ext_sel(ext_sel), .i_slow(slow),
      .o_strobe(strobe), .o_ext_clk(ext_clk), .o_qvld(qvld), .o_data(mem_data));

   // 100 MHz system clock
   initial begin
      i_clock = 1'b0;
      // one clock stands for system, write and command clocks: same rate, phase unused
      forever #5 i_clock = ~i_clock;
   end

   // fixed-seed xorshift so every run drives the same traffic
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // reference: init walk, then one command per taken request with write priority
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         k       = 0;
         pipe    = 16'h0;
         exp_cmd = {3'h7, 23'h0};
      end else begin
         k++;
         pipe    = pipe << 1;
         exp_cmd = {3'h7, 23'h0};
         if (k <= 9) begin
            exp_cmd.code = `LLC_CMD_MODE;
         end else if (k == 10) begin
            exp_cmd = {3'(`LLC_CMD_MODE), 3'h0, i_mode_config};
         end else if (k <= 18) begin
            exp_cmd = {3'(`LLC_CMD_REFRESH), 3'(k - 11), 20'h0};
         end else if (i_write_req) begin
            exp_cmd = {3'(`LLC_CMD_WRITE), i_bank_addr, i_addr};
            pipe[0] = 1'b1;
         end else if (i_read_req) begin
            exp_cmd = {3'(`LLC_CMD_READ), i_bank_addr, i_addr};
            rq.push_back(i_addr[17:0]);
         end else if (i_refresh_req) begin
            exp_cmd = {3'(`LLC_CMD_REFRESH), i_bank_addr, 20'h0};
         end
      end
   end

   // compare settled outputs once per cycle, read data and capture clock only with valid
   always @(negedge i_clock) begin
      check(64'(o_mem_cmd), 64'(exp_cmd));
      // take edge puts the write in bit 0, so the request shows WL-1 edges later
      check(64'(o_wdata_req), 64'(pipe[WL-1]));
      check(64'(o_init_done), 64'(k >= 18));
      check(64'(o_mem_clk_ddr), (k > 0) ? 64'h2 : 64'h0);
      if (o_rdata_valid === 1'b1) begin
         check(64'(o_rdata), 64'(rq.pop_front()));
         check(64'(o_capture_clk), 64'h1);
      end
   end

   task automatic idle();
      i_write_req   = 1'b0;
      i_read_req    = 1'b0;
      i_refresh_req = 1'b0;
   endtask

   // random back-to-back requests, reads kept rare so frames can keep up
   task automatic traffic(input int n);
      logic [31:0] r;
      repeat (n) begin
         @(negedge i_clock);
         r             = xs();
         i_write_req   = r[0] & r[1];
         i_read_req    = &r[5:2];
         i_refresh_req = r[6];
         i_bank_addr   = r[10:8];
         i_addr        = r[31:12];
      end
      @(negedge i_clock);
      idle();
   endtask

   // wait, bounded, until every expected read has come back
   task automatic drain(input string name);
      repeat (800) if (rq.size() != 0) @(negedge i_clock);
      check(64'(rq.size()), 64'h0);
      $display("test %s done", name);
   endtask

   task automatic do_reset();
      logic [31:0] r;
      r = xs();
      @(negedge i_clock);
      i_arst_n      = 1'b0;
      i_mode_config = r[19:0];
      repeat (3) @(posedge i_clock);
      // release lands on a rising edge, as the reset contract wants
      i_arst_n <= 1'b1;
   endtask

   initial begin
      idle();
      i_arst_n      = 1'b0;
      i_addr        = 20'h0;
      i_bank_addr   = 3'h0;
      i_mode_config = 20'h5a3c1;
      i_strobe_mode = 1'b1;
      ext_sel       = 1'b0;
      slow          = 1'b0;
      repeat (3) @(posedge i_clock);
      i_arst_n <= 1'b1;
      traffic(25);                // requests during init are ignored
      drain("init");
      traffic(200);
      drain("strobe traffic");
      for (int b = 0; b < 6; b++) begin
         @(negedge i_clock);
         // user side owns refresh and keeps each bank apart from other traffic here
         i_refresh_req = 1'b1;
         i_bank_addr   = 3'(b + 2);
      end
      @(negedge i_clock);
      idle();
      drain("ganged refresh");
      i_strobe_mode = 1'b0;
      ext_sel       = 1'b1;
      slow          = 1'b1;
      traffic(200);
      drain("external capture");
      do_reset();                 // second reset mid-run, new configuration word
      traffic(30);
      drain("second reset");
      end_sim();
   end

   // hang guard, far beyond the expected run of some 500 cycles
   initial begin
      #100us;
      miscompares++;
      end_sim();
   end
endmodule
